/* File: design/rdio_ctrl.sv */
// Dedicated remote-control I/O handling of the robot controller.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Teach mode output high in teach mode.
// R2: Auto mode output high in auto mode.
// R3: Remote mode output high in remote mode.
// R4: Ready output high after power-up completes.
// R5: Auto-enable level mirrored on enabled output.
// R6: Start edge runs all slots; operating shown.
// R7: Level halt on fixed input zero stops all.
// R8: Wait output high while halted slot paused.
// R9: Safety stops belong on emergency stop.
// R10: Second halt like first, number reassignable.
// R11: Functions bound to input/output signal numbers.
// R12: Level inputs act held; edge inputs on rise.
module rdio_ctrl (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Operating mode from the mode selector.
    input wire logic [1:0] mode_sel,
    // Program end report from the program engine.
    input wire logic prog_done,
    // Discrete input lines from the external controller.
    input wire logic [rdio_pkg::NUM_SIG-1:0] in_lines,
    // Reassignable input numbers.
    input wire logic [rdio_pkg::SIG_W-1:0] auto_en_num,
    input wire logic [rdio_pkg::SIG_W-1:0] start_num,
    input wire logic [rdio_pkg::SIG_W-1:0] halt2_num,
    // Output numbers, eight fields of four bits, status bit i at field i.
    input wire logic [8*rdio_pkg::SIG_W-1:0] out_nums,
    // Discrete output lines to the external controller.
    output logic [rdio_pkg::NUM_SIG-1:0] out_lines,
    // Individual status outputs.
    output logic teach_mode_out,
    output logic auto_mode_out,
    output logic remote_mode_out,
    output logic controller_ready_out,
    output logic auto_enabled_out,
    output logic operating_out,
    output logic wait_out
);

    // Selected input levels and edges.
    logic auto_operation_enable;
    logic start_lvl;
    logic start_rise;
    logic halt_lvl;
    logic reassignable_halt_in;
    // Power-up counter and run state.
    logic [rdio_pkg::PU_W-1:0] pu_cnt;
    logic [rdio_pkg::PU_W-1:0] next_pu_cnt;
    rdio_pkg::rdio_run_t run;
    rdio_pkg::rdio_run_t next_run;
    // Registered status bits.
    logic [7:0] status;
    logic [7:0] next_status;
    // Combined halt request.
    logic halt_any;

    // True when the mode selector holds the given mode; code 3 selects none.
    function automatic logic mode_is(input logic [1:0] sel, input rdio_pkg::rdio_mode_t m);
        return (sel == m);
    endfunction : mode_is

    // Output number of one status bit, cut from its field of the packed numbers.
    function automatic logic [rdio_pkg::SIG_W-1:0] out_num_of(
        input logic [8*rdio_pkg::SIG_W-1:0] nums,
        input int unsigned idx
    );
        return nums[idx*rdio_pkg::SIG_W +: rdio_pkg::SIG_W];
    endfunction : out_num_of

    // Automatic enable input, level type, at its assigned number.
    rdio_in_sel u_auto_en (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .lines(in_lines),
        .num(auto_en_num),
        .level(auto_operation_enable),
        .rise()
    );

    // Start input, edge type, at its assigned number.
    rdio_in_sel u_start (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .lines(in_lines),
        .num(start_num),
        .level(start_lvl),
        .rise(start_rise)
    );

    // Primary halt at its fixed number zero.
    rdio_in_sel u_halt (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .lines(in_lines),
        .num(rdio_pkg::HALT_IN_NUM), // [R7]
        .level(halt_lvl),
        .rise()
    );

    // Second halt at a reassignable number.
    rdio_in_sel u_halt2 (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .lines(in_lines),
        .num(halt2_num), // [R10]
        .level(reassignable_halt_in),
        .rise()
    );

    // Either halt acts while held, as both are level type.
    assign halt_any = halt_lvl || reassignable_halt_in; // [R7] [R10] [R12]

    // Power-up counter and slot run state next values.
    always_comb begin
        next_pu_cnt = pu_cnt;
        if (pu_cnt != rdio_pkg::PU_W'(rdio_pkg::POWERUP_CYC)) begin
            next_pu_cnt = pu_cnt + 1'b1; // [R4]
        end
        next_run = run;
        unique case (run)
            rdio_pkg::RDIO_IDLE: begin
                // Start acts only on its rising edge, and only if permitted.
                if (start_rise && !halt_any && auto_operation_enable && status[3]) begin
                    next_run = rdio_pkg::RDIO_RUN; // [R6] [R12] [R5]
                end
            end
            rdio_pkg::RDIO_RUN: begin
                // A held halt pauses the slots; completion idles them.
                if (halt_any) begin
                    next_run = rdio_pkg::RDIO_WAIT; // [R7] [R10]
                end else if (prog_done) begin
                    next_run = rdio_pkg::RDIO_IDLE;
                end
            end
            rdio_pkg::RDIO_WAIT: begin
                // A fresh start edge resumes once no halt is held.
                if (start_rise && !halt_any) begin
                    next_run = rdio_pkg::RDIO_RUN; // [R6]
                end
            end
            default: begin
                next_run = rdio_pkg::RDIO_IDLE;
            end
        endcase
    end

    // Status bits: teach, auto, remote, ready, enabled, operating, wait, wait2.
    always_comb begin
        next_status[0] = mode_is(mode_sel, rdio_pkg::RDIO_MODE_TEACH); // [R1]
        next_status[1] = mode_is(mode_sel, rdio_pkg::RDIO_MODE_AUTO); // [R2]
        next_status[2] = mode_is(mode_sel, rdio_pkg::RDIO_MODE_REMOTE); // [R3]
        next_status[3] = (pu_cnt == rdio_pkg::PU_W'(rdio_pkg::POWERUP_CYC)); // [R4]
        next_status[4] = auto_operation_enable; // [R5]
        next_status[5] = (run == rdio_pkg::RDIO_RUN); // [R6]
        next_status[6] = (run == rdio_pkg::RDIO_WAIT); // [R8]
        next_status[7] = (run == rdio_pkg::RDIO_WAIT); // [R10]
    end

    // Register counter, state and status.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt <= '0;
            run <= rdio_pkg::RDIO_IDLE;
            status <= 8'h00;
        end else begin
            pu_cnt <= next_pu_cnt;
            run <= next_run;
            status <= next_status;
        end
    end

    // Drive the individual status outputs from registers.
    assign teach_mode_out = status[0];
    assign auto_mode_out = status[1];
    assign remote_mode_out = status[2];
    assign controller_ready_out = status[3];
    assign auto_enabled_out = status[4];
    assign operating_out = status[5];
    assign wait_out = status[6];

    // Map status bits onto numbered output lines.
    rdio_out_map u_map (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .status(status),
        .nums(out_nums), // [R11]
        .lines(out_lines)
    );

    // Teach mode reported one cycle after selection.
    teach_out_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1]
        (mode_sel == rdio_pkg::RDIO_MODE_TEACH) |=> teach_mode_out)
        else $error("teach output missing");

    // Auto mode reported one cycle after selection.
    auto_out_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R2]
        (mode_sel == rdio_pkg::RDIO_MODE_AUTO) |=> (auto_mode_out && !teach_mode_out))
        else $error("auto output wrong");

    // Remote mode reported one cycle after selection.
    remote_out_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R3]
        (mode_sel == rdio_pkg::RDIO_MODE_REMOTE) |=> remote_mode_out)
        else $error("remote output missing");

    // Ready only rises after the power-up count has run.
    ready_time_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
        $rose(controller_ready_out) |-> ($past(pu_cnt) == rdio_pkg::PU_W'(rdio_pkg::POWERUP_CYC)))
        else $error("ready too early");

    // Enabled output follows the enable level one cycle later.
    auto_en_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
        auto_enabled_out == $past(auto_operation_enable))
        else $error("enable echo wrong");

    // A start edge from idle, permitted and unhalted, shows operating in two cycles.
    start_run_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
        (run == rdio_pkg::RDIO_IDLE && start_rise && !halt_any && auto_operation_enable
         && controller_ready_out) |-> ##2 operating_out)
        else $error("start did not run");

    // A held primary halt during run shows wait two cycles later.
    halt_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
        (run == rdio_pkg::RDIO_RUN && halt_lvl) |-> ##2 (wait_out && !operating_out))
        else $error("halt did not pause");

    // Wait never shows together with operating.
    wait_excl_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
        !(wait_out && operating_out))
        else $error("wait with operating");

    // The second halt pauses a run like the first.
    halt2_wait_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
        (run == rdio_pkg::RDIO_RUN && reassignable_halt_in) |=> (run == rdio_pkg::RDIO_WAIT))
        else $error("second halt ignored");

    // Operating status lands on its numbered output line.
    oper_line_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
        operating_out |=> out_lines[$past(out_nums[5*rdio_pkg::SIG_W +: rdio_pkg::SIG_W])])
        else $error("operating line missing");

    // A held start level without a new edge does not restart from wait.
    start_edge_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
        (run == rdio_pkg::RDIO_WAIT && !start_rise) |=> (run != rdio_pkg::RDIO_RUN))
        else $error("start acted without edge");

    // A start while not ready leaves the slots idle.
    start_refused_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
        (run == rdio_pkg::RDIO_IDLE && !controller_ready_out) |=> (run == rdio_pkg::RDIO_IDLE))
        else $error("start taken before ready");

    // Ready never drops again once power-up is over.
    ready_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R4]
        controller_ready_out |=> controller_ready_out)
        else $error("ready dropped");

    // Without the enable level no start leaves idle.
    enable_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R5]
        (run == rdio_pkg::RDIO_IDLE && !auto_operation_enable) |=> (run == rdio_pkg::RDIO_IDLE))
        else $error("start without enable");

    // A completion report shows operating low two cycles later.
    done_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R6]
        (run == rdio_pkg::RDIO_RUN && prog_done && !halt_any) |-> ##2 !operating_out)
        else $error("run did not end");

    // A held halt keeps idle slots from starting.
    halt_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R7]
        (run == rdio_pkg::RDIO_IDLE && halt_any) |=> (run == rdio_pkg::RDIO_IDLE))
        else $error("start while halted");

    // Paused slots stay paused while any halt is held.
    halt_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R8]
        (run == rdio_pkg::RDIO_WAIT && halt_any) |=> (run == rdio_pkg::RDIO_WAIT))
        else $error("resumed while halted");

    // The second halt also shows wait and drops operating.
    halt2_out_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
        (run == rdio_pkg::RDIO_RUN && reassignable_halt_in) |-> ##2 (wait_out && !operating_out))
        else $error("second halt no wait");

    // The copy of wait lands on its own numbered line.
    wait2_line_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R10]
        wait_out |=> out_lines[$past(out_num_of(out_nums, 7))])
        else $error("second wait line missing");

    // Teach status lands on its numbered output line.
    teach_line_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R11]
        teach_mode_out |=> out_lines[$past(out_num_of(out_nums, 0))])
        else $error("teach line missing");

    // A start level held over two cycles does not resume a pause.
    start_held_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R12]
        (run == rdio_pkg::RDIO_WAIT && start_lvl && $past(start_lvl)) |=> (run == rdio_pkg::RDIO_WAIT))
        else $error("held start resumed");

    // A selector code outside the three modes shows no mode output.
    mode_none_a: assert property (@(posedge sys_clk) disable iff (!nrst) // [R1] [R2] [R3]
        (!mode_is(mode_sel, rdio_pkg::RDIO_MODE_TEACH)
         && !mode_is(mode_sel, rdio_pkg::RDIO_MODE_AUTO)
         && !mode_is(mode_sel, rdio_pkg::RDIO_MODE_REMOTE))
        |=> !(teach_mode_out || auto_mode_out || remote_mode_out))
        else $error("mode output without mode");

endmodule : rdio_ctrl

/* File: design/rdio_in_sel.sv */
// Input selector that picks one line by number and reports level and rising edge.
`timescale 1ns/1ps
module rdio_in_sel (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Input lines and selected number.
    input wire logic [rdio_pkg::NUM_SIG-1:0] lines,
    input wire logic [rdio_pkg::SIG_W-1:0] num,
    // Selected level and rising edge.
    output logic level,
    output logic rise
);

    // Previous selected level for edge detection.
    logic prev;
    logic next_prev;

    // Pick the numbered line.
    always_comb begin
        level = lines[num];
        next_prev = level;
        rise = level && !prev;
    end

    // Store the previous level.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

endmodule : rdio_in_sel

/* File: design/rdio_out_map.sv */
// Output mapper that places eight status bits onto numbered output lines.
`timescale 1ns/1ps
module rdio_out_map (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Status bits and their output numbers.
    input wire logic [7:0] status,
    input wire logic [8*rdio_pkg::SIG_W-1:0] nums,
    // Registered output lines.
    output logic [rdio_pkg::NUM_SIG-1:0] lines
);

    // Next value of the output lines.
    logic [rdio_pkg::NUM_SIG-1:0] next_lines;

    // OR each status bit onto its numbered line, so shared numbers merge.
    always_comb begin
        next_lines = '0;
        for (int i = 0; i < 8; i++) begin
            if (status[i]) begin
                next_lines[nums[i*rdio_pkg::SIG_W +: rdio_pkg::SIG_W]] = 1'b1;
            end
        end
    end

    // Register the lines.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lines <= '0;
        end else begin
            lines <= next_lines;
        end
    end

endmodule : rdio_out_map

/* File: design/rdio_pkg.sv */
// Package with constants and types for the dedicated remote I/O block.
package rdio_pkg;

    // Number of discrete input and output signal lines on the interface.
    localparam int unsigned NUM_SIG = 16;
    // Width of a signal number that selects one line.
    localparam int unsigned SIG_W = 4;

    // Input number of the primary halt, fixed and not reconfigurable.
    localparam logic [3:0] HALT_IN_NUM = 4'h0;

    // Reset values of the reassignable input numbers.
    localparam logic [3:0] RST_AUTO_EN_IN = 4'h1;
    localparam logic [3:0] RST_START_IN = 4'h2;
    localparam logic [3:0] RST_HALT2_IN = 4'h3;

    // Reset values of the output numbers.
    localparam logic [3:0] RST_TEACH_OUT = 4'h0;
    localparam logic [3:0] RST_AUTOM_OUT = 4'h1;
    localparam logic [3:0] RST_REMOTE_OUT = 4'h2;
    localparam logic [3:0] RST_READY_OUT = 4'h3;
    localparam logic [3:0] RST_AUTOEN_OUT = 4'h4;
    localparam logic [3:0] RST_OPER_OUT = 4'h5;
    localparam logic [3:0] RST_WAIT_OUT = 4'h6;
    localparam logic [3:0] RST_WAIT2_OUT = 4'h7;

    // Power-up settle time in ns and the derived cycle count at 100 MHz.
    localparam int unsigned POWERUP_NS = 1000;
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned POWERUP_CYC = (POWERUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned PU_W = 8;

    // Operating modes of the controller.
    typedef enum logic [1:0] {
        RDIO_MODE_TEACH,
        RDIO_MODE_AUTO,
        RDIO_MODE_REMOTE
    } rdio_mode_t;

    // Run state of the program slots.
    typedef enum logic [1:0] {
        RDIO_IDLE,
        RDIO_RUN,
        RDIO_WAIT
    } rdio_run_t;

endpackage : rdio_pkg

/* File: testbench/rdio_ext_plc.sv */
// Model of the external controller that drives the dedicated input lines.
`timescale 1ns/1ps
module rdio_ext_plc (
    // Clock.
    input wire logic sys_clk,
    // Levels requested by the bench.
    input wire logic auto_en,
    input wire logic start,
    input wire logic halt,
    input wire logic halt2,
    // Input numbers in use.
    input wire logic [3:0] auto_en_num,
    input wire logic [3:0] start_num,
    input wire logic [3:0] halt2_num,
    // Input lines of the controller.
    output logic [15:0] in_lines
);
    // Lines with no function carry a pattern that changes every cycle.
    logic [15:0] noise = 16'h5a3c;

    // The pattern steps on the falling edge, away from the sampling edge.
    always @(negedge sys_clk) begin
        noise <= {noise[14:0], noise[15] ^ noise[13]};
    end

    // Functional lines override the pattern at their numbers.
    always_comb begin
        in_lines = noise;
        in_lines[0] = halt; // Ordinary halt only, never a safety stop.
        in_lines[auto_en_num] = auto_en; // Held as a level.
        in_lines[start_num] = start; // Pulses with a low gap between them.
        in_lines[halt2_num] = halt2;
    end
endmodule : rdio_ext_plc

/* File: testbench/robot_dedicated_io_control_bench.sv */
// Self-checking bench for the dedicated remote I/O block.
`timescale 1ns/1ps
module robot_dedicated_io_control_bench;
    // Clock, reset and stimulus.
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] mode_sel = 2'h3;
    logic prog_done = 1'b0;
    logic auto_en = 1'b0;
    logic start = 1'b0;
    logic halt = 1'b0;
    logic halt2 = 1'b0;
    logic [3:0] auto_en_num = rdio_pkg::RST_AUTO_EN_IN;
    logic [3:0] start_num = rdio_pkg::RST_START_IN;
    logic [3:0] halt2_num = rdio_pkg::RST_HALT2_IN;
    logic [31:0] out_nums = 32'h7654_3210;
    // Lines and status outputs.
    logic [15:0] in_lines;
    logic [15:0] out_lines;
    logic teach_mode_out, auto_mode_out, remote_mode_out, controller_ready_out;
    logic auto_enabled_out, operating_out, wait_out;
    // Model: run 0 idle, 1 running, 2 waiting; rdy set once power-up is over.
    int run = 0;
    int rdy = 0;
    int err_total = 0;
    int total_checks = 0;
    int i;
    logic [31:0] r;

    // Clock of 10 ns period.
    always #5 sys_clk = ~sys_clk;

    rdio_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .mode_sel(mode_sel),
        .prog_done(prog_done), .in_lines(in_lines), .auto_en_num(auto_en_num),
        .start_num(start_num), .halt2_num(halt2_num), .out_nums(out_nums),
        .out_lines(out_lines), .teach_mode_out(teach_mode_out),
        .auto_mode_out(auto_mode_out), .remote_mode_out(remote_mode_out),
        .controller_ready_out(controller_ready_out), .auto_enabled_out(auto_enabled_out),
        .operating_out(operating_out), .wait_out(wait_out));

    rdio_ext_plc plc (.sys_clk(sys_clk), .auto_en(auto_en), .start(start), .halt(halt),
        .halt2(halt2), .auto_en_num(auto_en_num), .start_num(start_num),
        .halt2_num(halt2_num), .in_lines(in_lines));

    // Compares one status bit.
    task automatic chk_bit(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    // Compares the sixteen output lines.
    task automatic chk_lines(input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL out_lines expected %h seen %h", exp, got);
        end
    endtask : chk_lines

    // Waits a number of falling edges.
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc

    // Lets the longest path settle, then compares every output with the model.
    task automatic check_all;
        logic [7:0] st;
        logic [15:0] ln;
        cyc(4);
        st = {run == 2, run == 2, run == 1, auto_en, rdy == 1, mode_sel == 2'h2,
            mode_sel == 2'h1, mode_sel == 2'h0};
        ln = 16'h0000;
        for (int k = 0; k < 8; k++) begin
            if (st[k]) begin
                ln[out_nums[4*k +: 4]] = 1'b1;
            end
        end
        chk_bit("teach", st[0], teach_mode_out);
        chk_bit("auto", st[1], auto_mode_out);
        chk_bit("remote", st[2], remote_mode_out);
        chk_bit("ready", st[3], controller_ready_out);
        chk_bit("auto_enabled", st[4], auto_enabled_out);
        chk_bit("operating", st[5], operating_out);
        chk_bit("wait", st[6], wait_out);
        chk_lines(ln, out_lines);
    endtask : check_all

    // Sends one start pulse and updates the model.
    task automatic do_start;
        if (!halt && !halt2 && (run == 2 || (run == 0 && rdy == 1 && auto_en))) begin
            run = 1;
        end
        start = 1'b1;
        cyc(2);
        start = 1'b0;
        check_all();
    endtask : do_start

    // Sets the fixed halt (sel 0) or the second halt (sel 1) to a level.
    task automatic do_halt(input int sel, input logic v);
        if (sel == 0) halt = v;
        else halt2 = v;
        if (v && run == 1) run = 2;
        check_all();
    endtask : do_halt

    // Reports the end of the running program.
    task automatic do_done;
        prog_done = 1'b1;
        if (run == 1) run = 0;
        cyc(1);
        prog_done = 1'b0;
        check_all();
    endtask : do_done

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    initial begin
        r = $urandom(48);
        check_all();
        cyc(12);
        nrst = 1'b1;
        auto_en = 1'b1;
        check_all();
        do_start();
        cyc(70);
        check_all();
        for (i = 0; i < 40 && controller_ready_out !== 1'b1; i++) cyc(1);
        if (i == 40) begin
            err_total++;
            $display("FAIL ready expected 1 seen %b", controller_ready_out);
            stop_test();
        end
        // Release lies 84 falling edges back; ready shows one edge after the count ends.
        chk_bit("ready_time", 1'b1, i == rdio_pkg::POWERUP_CYC - 83);
        rdy = 1;
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            mode_sel = i[1:0];
            check_all();
        end
        $display("test modes done");
        auto_en = 1'b0;
        do_start();
        auto_en = 1'b1;
        do_start();
        do_start();
        do_done();
        $display("test start done");
        do_start();
        do_halt(0, 1'b1);
        do_start();
        do_halt(0, 1'b0);
        do_start();
        do_done();
        $display("test halt done");
        r = $urandom;
        start_num = 4'h4 + 4'(r[3:0] % 6);
        halt2_num = 4'ha + 4'(r[7:4] % 6);
        r = $urandom;
        out_nums = {r[27:24], r[27:0]};
        do_start();
        do_halt(1, 1'b1);
        do_halt(1, 1'b0);
        do_start();
        do_done();
        $display("test reassign done");
        for (i = 0; i < 30; i++) begin
            r = $urandom % 4;
            case (r)
                0: do_start();
                1: do_halt(0, ~halt);
                2: do_halt(1, ~halt2);
                default: do_done();
            endcase
        end
        $display("test random done");
        stop_test();
    end
endmodule : robot_dedicated_io_control_bench
